// file: design/pfm_port_mux.sv
// How it works
// - Port 0 bit 2 defaults to reset input.
// - Every pin has software pull-up enable.
// - Port 1 bit 8 routes per code table.
// - Port 0 bit 4 routes per code table.
// - Port 0 bit 8 routes per code table.
// - Power stage raises fault line on failure.
// - Sleep control high runs, low sleeps.
// - LIN receive open-drain, low after wake-up.
// - Phase PWM high drives phase output high while sleep control is high.
// - Power stage SPI data directions are fixed.
// - UART/SPI data direction follows enables.
`timescale 1ns/1ns
module pfm_port_mux
(
  input  wire logic                     clock_i,              // System clock, 50 MHz.
  input  wire logic                     reset_i,              // Synchronous reset, active high.
  input  wire logic                     cfg_write_i,          // Configuration write strobe.
  input  wire logic [1:0]               cfg_pin_i,            // Pin index for the write.
  input  wire pfm_pkg::pfm_cfg_s        cfg_data_i,           // Configuration word to store.
  output      pfm_pkg::pfm_cfg_s        cfg_readback_o [pfm_pkg::NPIN], // Stored configuration.
  input  wire logic [pfm_pkg::NPIN-1:0] pin_in_i,             // Pad input levels.
  output      logic [pfm_pkg::NPIN-1:0] pin_out_o,            // Pad output levels.
  output      logic [pfm_pkg::NPIN-1:0] pin_oe_o,             // Pad output enables.
  output      logic [pfm_pkg::NPIN-1:0] pin_pull_up_o,        // Pad pull-up enables.
  input  wire logic [pfm_pkg::NFN-1:0]  fn_drive_i [pfm_pkg::NPIN], // Level each function drives.
  output      logic [pfm_pkg::NFN-1:0]  fn_sense_o [pfm_pkg::NPIN], // Level each function sees.
  output      logic                     ext_reset_n_o,        // External reset request, low active.
  input  wire logic [pfm_pkg::NPHASE-1:0] phase_pwm_i,        // Phase PWM levels from fixed channels.
  output      logic                     phase_one_output_o,   // Phase 1 output level.
  output      logic                     phase_two_output_o,   // Phase 2 output level.
  output      logic                     phase_three_output_o, // Phase 3 output level.
  output      logic                     phase_four_output_o,  // Phase 4 output level.
  input  wire logic                     power_stage_sleep_control_i, // High runs, low sleeps.
  output      logic                     power_stage_normal_o, // Power stage in normal mode.
  input  wire logic                     stage_failure_i,      // Failure detected in power stage.
  output      logic                     power_stage_fault_flag_o, // Fault line to port 1 bit 4.
  input  wire logic                     cs_one_ctrl_i,        // Port 1 bit 1 level.
  input  wire logic                     cs_two_ctrl_i,        // Port 1 bit 2 level.
  output      logic                     addressing_current_source_one_o, // Current source 1 on.
  output      logic                     addressing_current_source_two_o, // Current source 2 on.
  input  wire logic                     spi_mcu_out_i,        // Port 0 bit 12 data to stage.
  output      logic                     spi_stage_in_o,       // Data seen by the power stage.
  input  wire logic                     spi_stage_out_i,      // Data driven by the power stage.
  output      logic                     spi_mcu_in_o,         // Port 0 bit 13 data to the core.
  input  wire logic                     spi_select_i,         // Port 1 bit 3 chip select.
  input  wire logic                     spi_clock_i,          // Port 1 bit 7 clock.
  output      logic                     spi_stage_select_o,   // Chip select at the stage.
  output      logic                     spi_stage_clock_o,    // Clock at the stage.
  input  wire logic                     uart_txd_i,           // Port 1 bit 6 transmit data.
  input  wire logic                     lin_bus_i,            // LIN bus level.
  input  wire logic                     lin_wake_i,           // Wake-up event pulse.
  output      logic                     lin_drive_low_o,      // Transceiver pulls bus low.
  output      logic                     lin_rxd_oe_o          // Receive open-drain pulls low.
);

  localparam int NPIN = pfm_pkg::NPIN;
  localparam int NFN  = pfm_pkg::NFN;
  localparam int NPHASE_W = pfm_pkg::NPHASE;

  pfm_pkg::pfm_cfg_s        cfg      [NPIN];
  pfm_pkg::pfm_cfg_s        next_cfg [NPIN];
  logic [NPIN-1:0]          next_pin_out;
  logic [NPIN-1:0]          next_pin_oe;
  logic [NFN-1:0]           next_fn_sense [NPIN];
  logic                     next_ext_reset_n;
  logic [NPHASE_W-1:0]      next_phase;
  logic                     wake_hold;
  logic                     next_wake_hold;

  // Looks up the function that a code selects on a pin.
  function automatic pfm_pkg::pfm_fn_e lookup(input int pin, input logic [3:0] code);
    pfm_pkg::pfm_fn_e fn;
    fn = pfm_pkg::PFM_FN_NONE;
    if (code <= pfm_pkg::CODE_LIMIT)
    begin
      unique case (pin)
        pfm_pkg::PIN_P02: fn = pfm_pkg::MAP_P02[code];
        pfm_pkg::PIN_P04: fn = pfm_pkg::MAP_P04[code];
        pfm_pkg::PIN_P08: fn = pfm_pkg::MAP_P08[code];
        default:          fn = pfm_pkg::MAP_P18[code];
      endcase
    end
    return fn;
  endfunction

  // Level an input function sees when it is not selected.
  function automatic logic idle_level(input int fn);
    return (fn == int'(pfm_pkg::PFM_FN_RESET)) || (fn == int'(pfm_pkg::PFM_FN_SPI_CS))
        || (fn == int'(pfm_pkg::PFM_FN_BREAK));
  endfunction

  // Configuration registers.
  always_comb
  begin
    for (int p = 0; p < NPIN; p++)
    begin
      next_cfg[p] = cfg[p];
      if (cfg_write_i && (int'(cfg_pin_i) == p))
      begin
        next_cfg[p] = cfg_data_i;
      end
    end
  end

  always_ff @(posedge clock_i)
  begin
    for (int p = 0; p < NPIN; p++)
    begin
      if (reset_i)
      begin
        cfg[p].code              <= pfm_pkg::CODE_ZERO;
        cfg[p].pull_up           <= (p == pfm_pkg::PIN_P02) ? pfm_pkg::PU_RESET_PIN : pfm_pkg::PU_RESET;
        cfg[p].pin_input_enable  <= 1'b0;
        cfg[p].pin_output_enable <= 1'b0;
      end
      else
      begin
        cfg[p] <= next_cfg[p];
      end
    end
  end

  // Per-pin routing.
  generate
    for (genvar g = 0; g < NPIN; g++)
    begin : g_pin
      pfm_pkg::pfm_fn_e sel;
      assign sel = lookup(g, cfg[g].code);

      always_comb
      begin
        next_pin_out[g] = 1'b0;
        next_pin_oe[g]  = 1'b0;
        for (int f = 0; f < NFN; f++)
        begin
          next_fn_sense[g][f] = idle_level(f);
        end
        unique case (sel)
          pfm_pkg::PFM_FN_PWM, pfm_pkg::PFM_FN_CMP_OUT, pfm_pkg::PFM_FN_DBG_CLK,
          pfm_pkg::PFM_FN_ADC_TRIG:
          begin
            next_pin_out[g] = fn_drive_i[g][sel];
            next_pin_oe[g]  = 1'b1;
          end
          pfm_pkg::PFM_FN_UART, pfm_pkg::PFM_FN_SPI_DATA, pfm_pkg::PFM_FN_TIMER:
          begin
            next_pin_out[g] = fn_drive_i[g][sel];
            next_pin_oe[g]  = cfg[g].pin_output_enable;
            next_fn_sense[g][sel] = cfg[g].pin_input_enable ? pin_in_i[g] : idle_level(int'(sel));
          end
          pfm_pkg::PFM_FN_I2C_CLK:
          begin
            next_pin_oe[g] = ~fn_drive_i[g][sel];
            next_fn_sense[g][sel] = pin_in_i[g];
          end
          pfm_pkg::PFM_FN_RESET, pfm_pkg::PFM_FN_HALL, pfm_pkg::PFM_FN_BREAK,
          pfm_pkg::PFM_FN_SPI_CS, pfm_pkg::PFM_FN_SPI_CLK, pfm_pkg::PFM_FN_ANALOG:
          begin
            next_fn_sense[g][sel] = pin_in_i[g];
          end
          default:
          begin
            next_pin_oe[g] = 1'b0;
          end
        endcase
      end

      always_ff @(posedge clock_i)
      begin
        if (reset_i)
        begin
          pin_out_o[g]     <= 1'b0;
          pin_oe_o[g]      <= 1'b0;
          pin_pull_up_o[g] <= (g == pfm_pkg::PIN_P02) ? pfm_pkg::PU_RESET_PIN : pfm_pkg::PU_RESET;
          fn_sense_o[g]    <= '0;
          cfg_readback_o[g] <= '{code: pfm_pkg::CODE_ZERO, default: 1'b0,
                                 pull_up: (g == pfm_pkg::PIN_P02) ? pfm_pkg::PU_RESET_PIN : pfm_pkg::PU_RESET};
        end
        else
        begin
          pin_out_o[g]      <= next_pin_out[g];
          pin_oe_o[g]       <= next_pin_oe[g];
          pin_pull_up_o[g]  <= next_cfg[g].pull_up;
          fn_sense_o[g]     <= next_fn_sense[g];
          cfg_readback_o[g] <= next_cfg[g];
        end
      end
    end
  endgenerate

  // Reset request follows the reset function of port 0 bit 2.
  assign next_ext_reset_n = next_fn_sense[pfm_pkg::PIN_P02][int'(pfm_pkg::PFM_FN_RESET)];

  // Power stage, transceiver and fixed internal links.
  always_comb
  begin
    next_phase     = power_stage_sleep_control_i ? phase_pwm_i : '0;
    next_wake_hold = wake_hold;
    if (power_stage_sleep_control_i)
    begin
      next_wake_hold = 1'b0;
    end
    if (lin_wake_i)
    begin
      next_wake_hold = 1'b1;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      ext_reset_n_o                   <= 1'b1;
      phase_one_output_o              <= 1'b0;
      phase_two_output_o              <= 1'b0;
      phase_three_output_o            <= 1'b0;
      phase_four_output_o             <= 1'b0;
      power_stage_normal_o            <= 1'b0;
      power_stage_fault_flag_o        <= 1'b0;
      addressing_current_source_one_o <= 1'b0;
      addressing_current_source_two_o <= 1'b0;
      spi_stage_in_o                  <= 1'b0;
      spi_mcu_in_o                    <= 1'b0;
      spi_stage_select_o              <= 1'b1;
      spi_stage_clock_o               <= 1'b0;
      lin_drive_low_o                 <= 1'b0;
      lin_rxd_oe_o                    <= 1'b0;
      wake_hold                       <= 1'b0;
    end
    else
    begin
      ext_reset_n_o                   <= next_ext_reset_n;
      phase_one_output_o              <= next_phase[0];
      phase_two_output_o              <= next_phase[1];
      phase_three_output_o            <= next_phase[2];
      phase_four_output_o             <= next_phase[3];
      power_stage_normal_o            <= power_stage_sleep_control_i;
      power_stage_fault_flag_o        <= stage_failure_i;
      addressing_current_source_one_o <= cs_one_ctrl_i;
      addressing_current_source_two_o <= cs_two_ctrl_i;
      spi_stage_in_o                  <= spi_mcu_out_i;
      spi_mcu_in_o                    <= spi_stage_out_i;
      spi_stage_select_o              <= spi_select_i;
      spi_stage_clock_o               <= spi_clock_i;
      lin_drive_low_o                 <= ~uart_txd_i;
      lin_rxd_oe_o                    <= next_wake_hold | ~lin_bus_i;
      wake_hold                       <= next_wake_hold;
    end
  end

endmodule

// file: design/pfm_pkg.sv
package pfm_pkg;

  // Muxed pins handled here, in index order.
  localparam int NPIN    = 4;
  localparam int PIN_P02 = 0;
  localparam int PIN_P04 = 1;
  localparam int PIN_P08 = 2;
  localparam int PIN_P18 = 3;
  localparam int NCODE   = 10;
  localparam int CODE_W  = 4;
  localparam int NPHASE  = 4;

  typedef enum logic [3:0] {
    PFM_FN_NONE,
    PFM_FN_ANALOG,
    PFM_FN_RESET,
    PFM_FN_DBG_CLK,
    PFM_FN_HALL,
    PFM_FN_PWM,
    PFM_FN_BREAK,
    PFM_FN_UART,
    PFM_FN_SPI_CS,
    PFM_FN_SPI_CLK,
    PFM_FN_SPI_DATA,
    PFM_FN_I2C_CLK,
    PFM_FN_TIMER,
    PFM_FN_CMP_OUT,
    PFM_FN_ADC_TRIG
  } pfm_fn_e;

  localparam int NFN = 15;

  // Per-pin configuration word.
  typedef struct packed {
    logic [3:0] code;
    logic       pull_up;
    logic       pin_input_enable;
    logic       pin_output_enable;
  } pfm_cfg_s;

  localparam logic [3:0] CODE_ZERO     = 4'h0;
  localparam logic [3:0] CODE_LIMIT    = 4'h9;
  localparam logic       PU_RESET      = 1'b0;
  localparam logic       PU_RESET_PIN  = 1'b1;

  // Function tables, entry [n] is the function of selection code n.
  typedef pfm_fn_e [NCODE-1:0] pfm_map_t;

  localparam pfm_map_t MAP_P02 = '{
    PFM_FN_NONE, PFM_FN_NONE, PFM_FN_NONE, PFM_FN_NONE, PFM_FN_SPI_DATA,
    PFM_FN_NONE, PFM_FN_NONE, PFM_FN_NONE, PFM_FN_NONE, PFM_FN_RESET};
  localparam pfm_map_t MAP_P04 = '{
    PFM_FN_ADC_TRIG, PFM_FN_TIMER, PFM_FN_NONE, PFM_FN_I2C_CLK, PFM_FN_SPI_CS,
    PFM_FN_UART, PFM_FN_PWM, PFM_FN_HALL, PFM_FN_NONE, PFM_FN_ANALOG};
  localparam pfm_map_t MAP_P08 = '{
    PFM_FN_ADC_TRIG, PFM_FN_NONE, PFM_FN_TIMER, PFM_FN_I2C_CLK, PFM_FN_SPI_CLK,
    PFM_FN_UART, PFM_FN_BREAK, PFM_FN_NONE, PFM_FN_CMP_OUT, PFM_FN_ANALOG};
  localparam pfm_map_t MAP_P18 = '{
    PFM_FN_ADC_TRIG, PFM_FN_TIMER, PFM_FN_NONE, PFM_FN_I2C_CLK, PFM_FN_NONE,
    PFM_FN_UART, PFM_FN_PWM, PFM_FN_HALL, PFM_FN_DBG_CLK, PFM_FN_ANALOG};

endpackage

// file: verification/pfm_port_mux_assertions.sv
`timescale 1ns/1ns
module pfm_port_mux_assertions
(
  input wire logic                        clock_i,                         // Clock.
  input wire logic                        reset_i,                         // Reset.
  input wire logic                        cfg_write_i,                     // Write strobe.
  input wire logic [1:0]                  cfg_pin_i,                       // Pin index.
  input wire pfm_pkg::pfm_cfg_s           cfg_data_i,                      // Written word.
  input wire pfm_pkg::pfm_cfg_s           cfg_readback_o [pfm_pkg::NPIN],  // Stored words.
  input wire logic [pfm_pkg::NPHASE-1:0]  phase_pwm_i,                     // Phase PWM.
  input wire logic                        phase_one_output_o,              // Phase 1.
  input wire logic                        phase_two_output_o,              // Phase 2.
  input wire logic                        phase_three_output_o,            // Phase 3.
  input wire logic                        phase_four_output_o,             // Phase 4.
  input wire logic                        power_stage_sleep_control_i,     // Sleep control.
  input wire logic                        power_stage_normal_o,            // Normal mode.
  input wire logic                        stage_failure_i,                 // Failure.
  input wire logic                        power_stage_fault_flag_o,        // Fault line.
  input wire logic                        cs_one_ctrl_i,                   // Source 1 control.
  input wire logic                        cs_two_ctrl_i,                   // Source 2 control.
  input wire logic                        addressing_current_source_one_o, // Source 1.
  input wire logic                        addressing_current_source_two_o, // Source 2.
  input wire logic                        spi_mcu_out_i,                   // Data to stage.
  input wire logic                        spi_stage_in_o,                  // Seen by stage.
  input wire logic                        spi_stage_out_i,                 // Data from stage.
  input wire logic                        spi_mcu_in_o,                    // Seen by core.
  input wire logic                        uart_txd_i,                      // Transmit data.
  input wire logic                        lin_drive_low_o,                 // Bus pull-down.
  input wire logic                        lin_wake_i,                      // Wake pulse.
  input wire logic                        lin_rxd_oe_o                     // Receive pull-down.
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  phase_drive_a:
    assert property (!$past(reset_i) |-> {phase_four_output_o, phase_three_output_o, phase_two_output_o,
      phase_one_output_o} == ($past(phase_pwm_i) & {4{$past(power_stage_sleep_control_i)}})) else $error("phase level");
  sleep_mode_a:
    assert property (!$past(reset_i) |-> power_stage_normal_o == $past(power_stage_sleep_control_i))
      else $error("sleep mode");
  fault_flag_a:
    assert property ($rose(stage_failure_i) |=> power_stage_fault_flag_o ##1 $past(stage_failure_i) == power_stage_fault_flag_o)
      else $error("fault flag");
  current_sources_a:
    assert property (!$past(reset_i) |-> {addressing_current_source_two_o, addressing_current_source_one_o}
      == {$past(cs_two_ctrl_i), $past(cs_one_ctrl_i)}) else $error("current source");
  spi_data_a:
    assert property (!$past(reset_i) |-> spi_stage_in_o == $past(spi_mcu_out_i) && spi_mcu_in_o == $past(spi_stage_out_i))
      else $error("spi data");
  lin_transmit_a:
    assert property (!$past(reset_i) |-> lin_drive_low_o == !$past(uart_txd_i)) else $error("lin transmit");
  wake_hold_a:
    assert property (lin_wake_i |=> lin_rxd_oe_o) else $error("wake hold");
  cfg_store_a:
    assert property (cfg_write_i && cfg_data_i.code <= 4'h9 |=> cfg_readback_o[$past(cfg_pin_i)] == $past(cfg_data_i))
      else $error("config store");
endmodule
bind pfm_port_mux pfm_port_mux_assertions i_pfm_port_mux_assertions (.clock_i, .reset_i, .cfg_write_i, .cfg_pin_i,
  .cfg_data_i, .cfg_readback_o, .phase_pwm_i, .phase_one_output_o, .phase_two_output_o, .phase_three_output_o,
  .phase_four_output_o, .power_stage_sleep_control_i, .power_stage_normal_o, .stage_failure_i,
  .power_stage_fault_flag_o, .cs_one_ctrl_i, .cs_two_ctrl_i, .addressing_current_source_one_o,
  .addressing_current_source_two_o, .spi_mcu_out_i, .spi_stage_in_o, .spi_stage_out_i, .spi_mcu_in_o, .uart_txd_i,
  .lin_drive_low_o, .lin_wake_i, .lin_rxd_oe_o);

// file: verification/pfm_lin_partner.sv
`timescale 1ns/1ns
module pfm_lin_partner
(
  input  wire logic lin_drive_low_i, // Transceiver pulls the bus low.
  input  wire logic lin_rxd_oe_i,    // Receive line pulled low.
  output      logic lin_bus_o,       // Bus level with its pull-up.
  output      logic rxd_o            // Receive line with its pull-up.
);
  assign lin_bus_o = !lin_drive_low_i;
  assign rxd_o     = !lin_rxd_oe_i;
endmodule

// file: verification/pfm_port_mux_tb.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module pfm_port_mux_tb;
  logic clock_i, reset_i, cfg_write_i, power_stage_sleep_control_i, stage_failure_i, cs_one_ctrl_i, cs_two_ctrl_i;
  logic spi_mcu_out_i, spi_stage_out_i, spi_select_i, spi_clock_i, uart_txd_i, lin_bus_i, lin_wake_i, rxd;
  logic [1:0]               cfg_pin_i;
  pfm_pkg::pfm_cfg_s        cfg_data_i;
  pfm_pkg::pfm_cfg_s        cfg_readback_o [pfm_pkg::NPIN];
  logic [3:0]               pin_in_i, pin_out_o, pin_oe_o, pin_pull_up_o, phase_pwm_i;
  logic [pfm_pkg::NFN-1:0]  fn_drive_i [pfm_pkg::NPIN];
  logic [pfm_pkg::NFN-1:0]  fn_sense_o [pfm_pkg::NPIN];
  logic ext_reset_n_o, phase_one_output_o, phase_two_output_o, phase_three_output_o, phase_four_output_o;
  logic power_stage_normal_o, power_stage_fault_flag_o, addressing_current_source_one_o;
  logic addressing_current_source_two_o, spi_stage_in_o, spi_mcu_in_o, spi_stage_select_o, spi_stage_clock_o;
  logic lin_drive_low_o, lin_rxd_oe_o;
  logic [14:0] ex;
  int bad_count, compares, cyc, f;
  // Function index selected by each code, one nibble per code, code 0 lowest; pins P0.2, P0.4, P0.8, P1.8; P0.8 codes 1 and 2 hold each other's index.
  localparam logic [39:0] SEL [4] = '{40'h0000A00002, 40'hEC0B875401, 40'hE0CB976D01, 40'hEC0B075431};
  // Output-only functions (debug clock, PWM, comparator out, ADC trigger) keep seeing their idle level.
  localparam logic [14:0] OUT_ONLY = 15'h6028;
  pfm_port_mux i_pfm_port_mux (.*);
  pfm_lin_partner i_pfm_lin_partner (.lin_drive_low_i(lin_drive_low_o), .lin_rxd_oe_i(lin_rxd_oe_o),
    .lin_bus_o(lin_bus_i), .rxd_o(rxd));
  initial
  begin
    clock_i = 0;
    forever #10 clock_i = ~clock_i;
  end
  task automatic tick(int n = 1);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic wr(logic [1:0] p, logic [6:0] d);
    @(posedge clock_i);
    cfg_write_i <= 1;
    cfg_pin_i   <= p;
    cfg_data_i  <= d;
    @(posedge clock_i);
    cfg_write_i <= 0;
    tick();
  endtask
  task automatic links(logic [11:0] v);
    @(posedge clock_i);
    {power_stage_sleep_control_i, stage_failure_i, cs_one_ctrl_i, cs_two_ctrl_i, spi_mcu_out_i, spi_stage_out_i,
      spi_select_i, spi_clock_i, uart_txd_i} <= v[11:3];
    phase_pwm_i <= {v[0], v[2:0]};
    tick();
    `CHK("phases", {v[0], v[2:0]} & {4{v[11]}}, {phase_four_output_o, phase_three_output_o, phase_two_output_o, phase_one_output_o})
    `CHK("normal", v[11], power_stage_normal_o)
    `CHK("fault", v[10], power_stage_fault_flag_o)
    `CHK("sources", v[9:8], {addressing_current_source_one_o, addressing_current_source_two_o})
    `CHK("spi data", v[7:6], {spi_stage_in_o, spi_mcu_in_o})
    `CHK("spi ctrl", v[5:4], {spi_stage_select_o, spi_stage_clock_o})
    `CHK("lin drive", !v[3], lin_drive_low_o)
  endtask
  task automatic print_verdict;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      print_verdict();
    end
  end
  initial
  begin
    {reset_i, cfg_write_i, cfg_pin_i, cfg_data_i, lin_wake_i, phase_pwm_i, pin_in_i} = {4'h8, 7'h0, 1'b0, 8'hE};
    {power_stage_sleep_control_i, stage_failure_i, cs_one_ctrl_i, cs_two_ctrl_i, spi_mcu_out_i} = 0;
    {spi_stage_out_i, spi_select_i, spi_clock_i, uart_txd_i} = 4'h3;
    fn_drive_i = '{default: '0};
    tick(20);
    reset_i <= 0;
    tick(2);
    `CHK("reset pin", 1'b0, ext_reset_n_o)
    `CHK("pull ups", 4'h1, pin_pull_up_o)
    `CHK("code", 4'h0, cfg_readback_o[1].code)
    wr(0, {4'h5, 3'b010});
    tick();
    `CHK("reset pin", 1'b1, ext_reset_n_o)
    `CHK("pull ups", 4'h0, pin_pull_up_o)
    for (int p = 0; p < 4; p++)
      for (int c = 0; c <= 10; c++)
        for (int l = 0; l < 2; l++)
        begin
          pin_in_i[p] <= l[0];
          wr(p[1:0], {c[3:0], 3'b010});
          tick();
          f  = (c > 9) ? 0 : SEL[p][c*4 +: 4];
          ex = (l[0] && !OUT_ONLY[f]) ? (15'h0144 | (15'h1 << f)) : (15'h0144 & ~(15'h1 << f));
          `CHK("sense", ex & 15'h7FFC, fn_sense_o[p] & 15'h7FFC)
        end
    fn_drive_i[1] <= 15'h1 << pfm_pkg::PFM_FN_UART;
    wr(1, {4'h4, 3'b001});
    `CHK("uart out", 2'b11, {pin_oe_o[1], pin_out_o[1]})
    wr(1, {4'hA, 3'b001});
    `CHK("refused oe", 1'b0, pin_oe_o[1])
    links(12'b1110_1001_0101);
    links(12'b0101_0110_1010);
    links(12'b1000_0000_1111);
    tick();
    `CHK("rxd idle", 1'b1, rxd)
    links(12'b0000_0000_1000);
    lin_wake_i <= 1;
    tick();
    lin_wake_i <= 0;
    tick(3);
    `CHK("rxd held", 1'b0, rxd)
    power_stage_sleep_control_i <= 1;
    tick(3);
    `CHK("rxd freed", 1'b1, rxd)
    print_verdict();
  end
endmodule
